// ===== rtl/pin_port_pkg.sv
`default_nettype none
package pin_port_pkg;
	// Register location in configuration space (byte address)
	localparam logic [7:0] PIN_PORT_OFFSET = 8'hE8;
	localparam logic [31:0] PIN_PORT_RESET = 32'h0000_0000;
	// Status and output data field positions
	localparam int VOL_DOWN_STATUS_BIT = 0;
	localparam int VOL_UP_STATUS_BIT = 1;
	localparam int SHARED_PIN_STATUS_BIT = 2;
	localparam int SECOND_PIN_STATUS_BIT = 3;
	localparam int SECONDARY_IRQ_BIT = 4;
	localparam int PRIMARY_IRQ_BIT = 5;
	localparam int SHARED_OUT_DATA_BIT = 10;
	localparam int SECOND_OUT_DATA_BIT = 11;
	// Control nibbles: base bit of each 4-bit group (source/dir, pol, sticky, wake)
	localparam int VOL_DOWN_CTL_BASE = 16;
	localparam int VOL_UP_CTL_BASE = 20;
	localparam int SHARED_CTL_BASE = 24;
	localparam int SECOND_CTL_BASE = 28;
	// Pin-input synchroniser depth
	localparam int SYNC_STAGES = 3;

	// One 4-bit control group per pin
	typedef struct packed {
		logic wake;
		logic sticky;
		logic polarity;
		logic low_bit;
	} pin_ctl_t;

	// Configuration cycle request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} cfg_req_t;

	// Synchronised pin samples
	typedef struct packed {
		logic vol_down;
		logic vol_up;
		logic shared_pin;
		logic second_pin;
		logic sec_irq;
		logic pri_irq;
	} pin_in_t;
endpackage
`default_nettype wire

// ===== rtl/volume_and_gpio_pin_port.sv
// Functional notes
// - Sticky volume-down latches on active edge
// - Level volume-down shows qualified pin
// - Sticky volume-up latches, cleared by zero
// - Level volume-up follows qualified pin
// - Polarity bit: zero low, one high
// - Shared output pin status reads pin level
// - Shared input sticky or level status
// - Second output pin status reads pin
// - Second input sticky or level status
// - Secondary codec irq copy, local clear
// - Primary codec irq copy, local clear
// - Shared pin driven from its data bit
// - Second pin driven from its data bit
// - Shared enable resets zero, blocked by serial
// - Second enable resets zero, drives buffer
// - Shared polarity or drive type select
// - Second polarity or drive type select
// - Volume-down source or pull-up select
// - Volume-up source or pull-up select
// - Volume wake only in sticky mode
// - GPIO wake sticky, shared not serial
// - Serial enable resets zero, claims pin
`timescale 1ns/1ps
`default_nettype none
module volume_and_gpio_pin_port
	import pin_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	// Configuration cycle port
	input wire logic cfg_rd,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	// Write protect from the configuration block: high allows writes
	input wire logic cfg_write_open,
	// Secondary serial input claim of the shared pin
	input wire logic secondary_input_enable,
	// Hardware volume control enable and its change pulses
	input wire logic hw_volume_enable,
	input wire logic vol_down_change_pulse,
	input wire logic vol_up_change_pulse,
	// Codec slot-12 interrupt flags, same clock domain
	input wire logic pri_codec_pin_interrupt,
	input wire logic sec_codec_pin_interrupt,
	// Pins
	input wire logic volume_down_pin,
	input wire logic volume_up_pin,
	input wire logic shared_serial_in_pin_i,
	output logic shared_serial_in_pin_o,
	output logic shared_serial_in_pin_oe,
	input wire logic second_general_pin_i,
	output logic second_general_pin_o,
	output logic second_general_pin_oe,
	// Pull-up enables for the volume pins
	output logic vol_down_pullup_en,
	output logic vol_up_pullup_en,
	// Wake event request toward power management
	output logic power_wake_event
);
	// Whole module state
	typedef struct packed {
		logic [SYNC_STAGES-1:0] s_vdn;
		logic [SYNC_STAGES-1:0] s_vup;
		logic [SYNC_STAGES-1:0] s_sh;
		logic [SYNC_STAGES-1:0] s_sec;
		pin_in_t prev;            // Previous qualified levels for edge detect
		// Last accepted pin levels, order {second, shared, up, down}
		logic [3:0] steady;
		logic [5:0] sticky;       // Latched status bits 0..5
		pin_ctl_t vdn_ctl;
		pin_ctl_t vup_ctl;
		pin_ctl_t sh_ctl;
		pin_ctl_t sec_ctl;
		logic sh_data;
		logic sec_data;
		logic [31:0] rdata;
		logic rvalid;
		logic sh_o;
		logic sh_oe;
		logic sec_o;
		logic sec_oe;
		logic vdn_pu;
		logic vup_pu;
		logic wake;
	} state_t;

	state_t st_q;
	state_t st_d;

	// Stable level: second and third synchroniser stages agree, else hold
	function automatic logic settled(input logic [SYNC_STAGES-1:0] s, input logic hold);
		settled = (s[SYNC_STAGES-1] == s[SYNC_STAGES-2]) ? s[SYNC_STAGES-1] : hold;
	endfunction

	// Polarity qualification: a clear polarity bit means the pin is active low,
	// so the level is inverted before edge detect and level status.
	// Used for all four pins, hence one shared helper
	function automatic logic qualify(input logic raw, input logic pol);
		qualify = raw ^ ~pol;
	endfunction

	// Sticky update: set wins over a clearing zero write; one holds
	function automatic logic sticky_next(input logic cur, input logic set,
		input logic wr, input logic wbit);
		sticky_next = set | (cur & ~(wr & ~wbit));
	endfunction

	// Working values
	// Combinational scratch, all given a value on every pass
	logic wr_hit;
	logic rd_hit;
	logic vdn_raw;
	logic vup_raw;
	logic sh_raw;
	logic sec_raw;
	pin_in_t lvl;
	pin_in_t rise;
	logic sh_is_out;
	logic sec_is_out;
	logic [5:0] stat;
	logic [31:0] word;
	logic [31:0] nw;
	logic held_vdn;
	logic held_vup;
	logic held_sh;
	logic held_sec;

	// Next-state logic
	always_comb
	begin
		st_d = st_q;
		// Write protect and address both gate a write; reads are never blocked
		wr_hit = cfg_wr && cfg_write_open && (cfg_addr == PIN_PORT_OFFSET);
		rd_hit = cfg_rd && (cfg_addr == PIN_PORT_OFFSET);
		// synchroniser shift
		// Three flops per pin; only the shift itself reads the first stage
		st_d.s_vdn = {st_q.s_vdn[SYNC_STAGES-2:0], volume_down_pin};
		st_d.s_vup = {st_q.s_vup[SYNC_STAGES-2:0], volume_up_pin};
		st_d.s_sh = {st_q.s_sh[SYNC_STAGES-2:0], shared_serial_in_pin_i};
		st_d.s_sec = {st_q.s_sec[SYNC_STAGES-2:0], second_general_pin_i};
		// Held levels are the last accepted ones, so a stage pair that still
		// disagrees cannot pass a half-resolved sample on to edge detect
		held_vdn = st_q.steady[0];
		held_vup = st_q.steady[1];
		held_sh = st_q.steady[2];
		held_sec = st_q.steady[3];
		vdn_raw = settled(st_q.s_vdn, held_vdn);
		vup_raw = settled(st_q.s_vup, held_vup);
		sh_raw = settled(st_q.s_sh, held_sh);
		sec_raw = settled(st_q.s_sec, held_sec);
		// Remember the accepted levels before any pulse source replaces them
		st_d.steady = {sec_raw, sh_raw, vup_raw, vdn_raw};
		// volume-down source under hardware volume control
		if (hw_volume_enable && st_q.vdn_ctl.low_bit)
			vdn_raw = vol_down_change_pulse;
		// volume-up source under hardware volume control
		if (hw_volume_enable && st_q.vup_ctl.low_bit)
			vup_raw = vol_up_change_pulse;
		sh_is_out = st_q.sh_ctl.low_bit && !secondary_input_enable;
		sec_is_out = st_q.sec_ctl.low_bit;
		// polarity qualification, zero means active low
		lvl.vol_down = qualify(vdn_raw, st_q.vdn_ctl.polarity);
		lvl.vol_up = qualify(vup_raw, st_q.vup_ctl.polarity);
		// shared polarity applies while input; as an output the same
		// bit picks the drive type and the status reads the pin instead
		lvl.shared_pin = qualify(sh_raw, st_q.sh_ctl.polarity);
		lvl.second_pin = qualify(sec_raw, st_q.sec_ctl.polarity);
		lvl.sec_irq = sec_codec_pin_interrupt;
		lvl.pri_irq = pri_codec_pin_interrupt;
		rise = lvl & ~st_q.prev;
		st_d.prev = lvl;
		// Gate edges that must not latch: only sticky inputs keep an edge, and
		// an output pin never latches its own drive back as an input event
		// volume edges count in sticky mode only
		rise.vol_down = rise.vol_down & st_q.vdn_ctl.sticky;
		rise.vol_up = rise.vol_up & st_q.vup_ctl.sticky;
		// shared edges are dropped while the serial input owns it
		rise.shared_pin = rise.shared_pin & st_q.sh_ctl.sticky & ~sh_is_out
			& ~secondary_input_enable;
		// second pin edges count only while it is an input
		rise.second_pin = rise.second_pin & st_q.sec_ctl.sticky & ~sec_is_out;
		st_d.sticky[VOL_DOWN_STATUS_BIT] = sticky_next(st_q.sticky[VOL_DOWN_STATUS_BIT],
			rise.vol_down, wr_hit && cfg_be[0], cfg_wdata[VOL_DOWN_STATUS_BIT]);
		st_d.sticky[VOL_UP_STATUS_BIT] = sticky_next(st_q.sticky[VOL_UP_STATUS_BIT],
			rise.vol_up, wr_hit && cfg_be[0], cfg_wdata[VOL_UP_STATUS_BIT]);
		st_d.sticky[SHARED_PIN_STATUS_BIT] = sticky_next(st_q.sticky[SHARED_PIN_STATUS_BIT],
			rise.shared_pin, wr_hit && cfg_be[0], cfg_wdata[SHARED_PIN_STATUS_BIT]);
		st_d.sticky[SECOND_PIN_STATUS_BIT] = sticky_next(st_q.sticky[SECOND_PIN_STATUS_BIT],
			rise.second_pin, wr_hit && cfg_be[0], cfg_wdata[SECOND_PIN_STATUS_BIT]);
		// codec copies; codec source is cleared by software elsewhere
		st_d.sticky[SECONDARY_IRQ_BIT] = sticky_next(st_q.sticky[SECONDARY_IRQ_BIT],
			rise.sec_irq, wr_hit && cfg_be[0], cfg_wdata[SECONDARY_IRQ_BIT]);
		st_d.sticky[PRIMARY_IRQ_BIT] = sticky_next(st_q.sticky[PRIMARY_IRQ_BIT],
			rise.pri_irq, wr_hit && cfg_be[0], cfg_wdata[PRIMARY_IRQ_BIT]);
		// Control writes, byte enables respected
		// A write with only byte zero enabled clears the status bits written as zero and leaves control alone
		nw = cfg_wdata;
		if (wr_hit && cfg_be[1])
		begin
			// Byte one holds both output data bits
			st_d.sh_data = nw[SHARED_OUT_DATA_BIT];
			st_d.sec_data = nw[SECOND_OUT_DATA_BIT];
		end
		if (wr_hit && cfg_be[2])
		begin
			// Byte two holds the two volume control groups
			st_d.vdn_ctl = nw[VOL_DOWN_CTL_BASE +: 4];
			st_d.vup_ctl = nw[VOL_UP_CTL_BASE +: 4];
		end
		if (wr_hit && cfg_be[3])
		begin
			// Byte three holds the two general pin control groups
			st_d.sh_ctl = nw[SHARED_CTL_BASE +: 4];
			st_d.sec_ctl = nw[SECOND_CTL_BASE +: 4];
		end
		// level mode shows qualified pin; outputs read pin
		// Sticky copies are the default; level and output cases override them
		stat = st_q.sticky;
		if (!st_q.vdn_ctl.sticky)
			stat[VOL_DOWN_STATUS_BIT] = lvl.vol_down;
		if (!st_q.vup_ctl.sticky)
			stat[VOL_UP_STATUS_BIT] = lvl.vol_up;
		if (sh_is_out)
			stat[SHARED_PIN_STATUS_BIT] = sh_raw;
		else if (!st_q.sh_ctl.sticky)
			stat[SHARED_PIN_STATUS_BIT] = lvl.shared_pin;
		if (sec_is_out)
			stat[SECOND_PIN_STATUS_BIT] = sec_raw;
		else if (!st_q.sec_ctl.sticky)
			stat[SECOND_PIN_STATUS_BIT] = lvl.second_pin;
		// Read word assembly; reserved bits read zero
		// Control fields read back exactly as written
		word = 32'h0000_0000;
		word[5:0] = stat;
		word[SHARED_OUT_DATA_BIT] = st_q.sh_data;
		word[SECOND_OUT_DATA_BIT] = st_q.sec_data;
		word[VOL_DOWN_CTL_BASE +: 4] = st_q.vdn_ctl;
		word[VOL_UP_CTL_BASE +: 4] = st_q.vup_ctl;
		word[SHARED_CTL_BASE +: 4] = st_q.sh_ctl;
		word[SECOND_CTL_BASE +: 4] = st_q.sec_ctl;
		// Unmapped reads return zero, still answered; the data word is kept
		// until the next read so a slow master may pick it up late
		st_d.rvalid = cfg_rd;
		if (cfg_rd)
		begin
			// Answer word for this read
			st_d.rdata = rd_hit ? word : 32'h0000_0000;
		end
		// Open drain: the buffer turns off for a one and the pin floats to the
		// board level; the status then shows whatever the board holds
		// shared pin drive, blocked while serial owns it
		st_d.sh_o = st_d.sh_data;
		st_d.sh_oe = st_d.sh_ctl.low_bit && !secondary_input_enable
			&& !(st_d.sh_ctl.polarity && st_d.sh_data);
		// second pin drive, open drain releases on one
		st_d.sec_o = st_d.sec_data;
		st_d.sec_oe = st_d.sec_ctl.low_bit
			&& !(st_d.sec_ctl.polarity && st_d.sec_data);
		// pull-up enabled by zero when hardware volume is off
		// Under hardware volume control the pull-up is left to the board
		st_d.vdn_pu = !hw_volume_enable && !st_d.vdn_ctl.low_bit;
		st_d.vup_pu = !hw_volume_enable && !st_d.vup_ctl.low_bit;
		// wake from sticky inputs only
		// A one-cycle pulse in any cycle with a latching edge whose wake bit is set; the codec copies never wake from here
		st_d.wake = (rise.vol_down & st_q.vdn_ctl.wake)
			| (rise.vol_up & st_q.vup_ctl.wake)
			| (rise.shared_pin & st_q.sh_ctl.wake)
			| (rise.second_pin & st_q.sec_ctl.wake);
	end

	// State register; control resets to zero
	// Every output reads zero while reset is low, pull-ups included
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// Outputs straight from flip-flops
	// No logic sits between the state register and the pins, so nothing glitches
	assign cfg_rdata = st_q.rdata;
	assign cfg_rvalid = st_q.rvalid;
	assign shared_serial_in_pin_o = st_q.sh_o;
	assign shared_serial_in_pin_oe = st_q.sh_oe;
	assign second_general_pin_o = st_q.sec_o;
	assign second_general_pin_oe = st_q.sec_oe;
	assign vol_down_pullup_en = st_q.vdn_pu;
	assign vol_up_pullup_en = st_q.vup_pu;
	assign power_wake_event = st_q.wake;
endmodule
`default_nettype wire

// ===== tb/pin_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level watch on the pin port; one clock domain only
module pin_port_chk
	import pin_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic cfg_rd,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_rvalid,
	input wire logic secondary_input_enable,
	input wire logic hw_volume_enable,
	input wire logic shared_serial_in_pin_oe,
	input wire logic second_general_pin_o,
	input wire logic second_general_pin_oe,
	input wire logic vol_down_pullup_en,
	input wire logic vol_up_pullup_en
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	property p_read_answer; cfg_rd |=> cfg_rvalid; endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");
	property p_no_stray; !cfg_rd |=> !cfg_rvalid; endproperty
	a_no_stray: assert property (p_no_stray) else $error("answer without read");
	property p_rdata_hold; !cfg_rd |=> $stable(cfg_rdata); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_unmapped; cfg_rd && cfg_addr != PIN_PORT_OFFSET |=> cfg_rdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_serial_blocks; secondary_input_enable && $past(secondary_input_enable)
		&& $past(secondary_input_enable, 2) |-> !shared_serial_in_pin_oe; endproperty
	a_serial_blocks: assert property (p_serial_blocks) else $error("shared pin driven");
	property p_reset_quiet; !$past(rst_b) |-> !shared_serial_in_pin_oe && !second_general_pin_oe;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("pin driven at reset");
	property p_second_hold; !cfg_wr && !$past(cfg_wr)
		|=> $stable({second_general_pin_o, second_general_pin_oe}); endproperty
	a_second_hold: assert property (p_second_hold) else $error("second pin moved");
	property p_pullup_hold; $past(rst_b) && !cfg_wr && !$past(cfg_wr)
		&& $stable(hw_volume_enable)
		&& hw_volume_enable == $past(hw_volume_enable, 2)
		|=> $stable({vol_down_pullup_en, vol_up_pullup_en}); endproperty
	a_pullup_hold: assert property (p_pullup_hold) else $error("pull-up moved");
endmodule
bind volume_and_gpio_pin_port pin_port_chk chk (.ref_clk(ref_clk), .rst_b(rst_b),
	.cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
	.cfg_rvalid(cfg_rvalid), .secondary_input_enable(secondary_input_enable),
	.hw_volume_enable(hw_volume_enable), .shared_serial_in_pin_oe(shared_serial_in_pin_oe),
	.second_general_pin_o(second_general_pin_o), .second_general_pin_oe(second_general_pin_oe),
	.vol_down_pullup_en(vol_down_pullup_en), .vol_up_pullup_en(vol_up_pullup_en));
`default_nettype wire

// ===== tb/pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Buttons and general pins outside the device
module pin_partner
(
	input wire logic [3:0] ext_level,
	input wire logic shared_o,
	input wire logic shared_oe,
	input wire logic second_o,
	input wire logic second_oe,
	output logic [3:0] pin_level
);
	// wire level, device wins while it drives
	assign pin_level = {second_oe ? second_o : ext_level[3],
		shared_oe ? shared_o : ext_level[2], ext_level[1:0]};
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import pin_port_pkg::*;
;
	// Row: control word, pin levels, status and {oe, oe, pull-up, pull-up}
	typedef struct packed {
		logic [31:0] ctl;
		logic [3:0] pins;
		logic [3:0] st;
		logic [3:0] outs;
	} row_t;
	localparam row_t ROWS [9] = '{
		'{32'h0000_0000, 4'h0, 4'hF, 4'h3}, '{32'h0000_0000, 4'hF, 4'h0, 4'h3},
		'{32'h2222_0000, 4'hF, 4'hF, 4'h3}, '{32'h2233_0000, 4'h5, 4'h5, 4'h0},
		'{32'h1000_0800, 4'h0, 4'hF, 4'h7}, '{32'h3000_0800, 4'h0, 4'h7, 4'h3},
		'{32'h0100_0400, 4'h0, 4'hF, 4'hB}, '{32'h1100_0000, 4'hF, 4'h0, 4'hF},
		'{32'h3300_0000, 4'hF, 4'h0, 4'hF}};
	logic ref_clk = 1'b0, rst_b = 1'b0, cfg_rd = 1'b0, cfg_wr = 1'b0, cfg_write_open = 1'b1;
	logic sec_en = 1'b0, hw_vol = 1'b0, cfg_rvalid, sh_o, sh_oe, sc_o, sc_oe, vdn_pu, vup_pu, wake;
	logic [1:0] vol_pulse = 2'h0, codec_irq = 2'h0;
	logic [7:0] cfg_addr = PIN_PORT_OFFSET;
	logic [3:0] cfg_be = 4'h0, ext_level = 4'h0, pin_level;
	logic [31:0] cfg_wdata = 32'h0000_0000, cfg_rdata, rd, mask;
	int mismatches = 0, samples_checked = 0, cycles = 0, wakes = 0, base;
	always #4 ref_clk = ~ref_clk;
	volume_and_gpio_pin_port uut (.ref_clk(ref_clk), .rst_b(rst_b), .cfg_rd(cfg_rd),
		.cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .cfg_write_open(cfg_write_open),
		.secondary_input_enable(sec_en), .hw_volume_enable(hw_vol),
		.vol_down_change_pulse(vol_pulse[0]), .vol_up_change_pulse(vol_pulse[1]),
		.pri_codec_pin_interrupt(codec_irq[1]), .sec_codec_pin_interrupt(codec_irq[0]),
		.volume_down_pin(pin_level[0]), .volume_up_pin(pin_level[1]),
		.shared_serial_in_pin_i(pin_level[2]), .shared_serial_in_pin_o(sh_o),
		.shared_serial_in_pin_oe(sh_oe), .second_general_pin_i(pin_level[3]),
		.second_general_pin_o(sc_o), .second_general_pin_oe(sc_oe), .vol_down_pullup_en(vdn_pu),
		.vol_up_pullup_en(vup_pu), .power_wake_event(wake));
	pin_partner far_side (.ext_level(ext_level), .shared_o(sh_o), .shared_oe(sh_oe),
		.second_o(sc_o), .second_oe(sc_oe), .pin_level(pin_level));
	// Inputs move 1 ns after the edge, away from sampling
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Idle edge after the strobe so back-to-back calls never retoggle it
	task automatic cfg_write(input logic [3:0] be, input logic [31:0] data);
		cfg_wr = 1'b1;
		cfg_be = be;
		cfg_wdata = data;
		tick(1);
		cfg_wr = 1'b0;
		tick(1);
	endtask
	task automatic cfg_read;
		int n;
		n = 0;
		cfg_rd = 1'b1;
		tick(1);
		cfg_rd = 1'b0;
		while (cfg_rvalid !== 1'b1 && n < 4)
		begin
			tick(1);
			n++;
		end
		if (n == 4)
			mismatches++;
		rd = cfg_rdata;
	endtask
	task automatic pulse_pin(input int i);
		ext_level[i] = 1'b1;
		tick(8);
		ext_level[i] = 1'b0;
		tick(8);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Wake pulse count and hang guard
	always @(posedge ref_clk)
	begin
		cycles++;
		if (wake === 1'b1)
			wakes++;
		if (cycles == 20000)
		begin
			mismatches++;
			complete_run();
		end
	end
	initial
	begin
		tick(12);
		rst_b = 1'b1;
		tick(1);
		cfg_read();
		check(rd & 32'hFFFF_FFF0, PIN_PORT_RESET);
		foreach (ROWS[i])
		begin
			cfg_write(4'hF, ROWS[i].ctl);
			ext_level = ROWS[i].pins;
			tick(8);
			cfg_read();
			check(rd & 32'h0000_000F, {28'h0, ROWS[i].st});
			check({28'h0, sh_oe, sc_oe, vdn_pu, vup_pu}, {28'h0, ROWS[i].outs});
		end
		$display("table done");
		// Each pin in turn: sticky latch, wake, hold on one, clear on zero
		for (int i = 0; i < 4; i++)
		begin
			mask = 32'h1 << i;
			ext_level = 4'h0;
			cfg_write(4'hF, 32'h000E_0000 << (4 * i));
			tick(8);
			cfg_write(4'h1, 32'h0000_0000);
			base = wakes;
			pulse_pin(i);
			cfg_read();
			check(rd & mask, mask);
			check(32'(wakes - base), 32'h1);
			cfg_write(4'h1, 32'h0000_000F);
			cfg_read();
			check(rd & mask, mask);
			cfg_write(4'h1, 32'h0000_0000);
			cfg_read();
			check(rd & mask, 32'h0);
			cfg_write(4'hF, 32'h000A_0000 << (4 * i));
			base = wakes;
			pulse_pin(i);
			check(32'(wakes - base), 32'h0);
		end
		$display("sticky done");
		// Serial use takes the shared pin
		sec_en = 1'b1;
		cfg_write(4'hF, 32'h0E00_0000);
		base = wakes;
		pulse_pin(2);
		check(32'(wakes - base), 32'h0);
		cfg_write(4'hF, 32'h0100_0400);
		tick(3);
		check({31'h0, sh_oe}, 32'h0);
		sec_en = 1'b0;
		tick(3);
		check({31'h0, sh_oe}, 32'h1);
		for (int j = 0; j < 2; j++)
		begin
			mask = 32'h1 << (SECONDARY_IRQ_BIT + j);
			codec_irq[j] = 1'b1;
			tick(2);
			codec_irq[j] = 1'b0;
			tick(4);
			cfg_read();
			check(rd & mask, mask);
			cfg_write(4'h1, 32'h0000_0000);
			cfg_read();
			check(rd & mask, 32'h0);
		end
		// Set and clear in one cycle: the new edge must win
		codec_irq[0] = 1'b1;
		cfg_write(4'h1, 32'h0000_0000);
		codec_irq[0] = 1'b0;
		cfg_read();
		check(rd & 32'h10, 32'h10);
		cfg_write(4'h1, 32'h0000_0000);
		cfg_read();
		check(rd & 32'h10, 32'h0);
		$display("codec done");
		hw_vol = 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			cfg_write(4'hF, 32'h0007_0000 << (4 * i));
			vol_pulse[i] = 1'b1;
			tick(1);
			vol_pulse[i] = 1'b0;
			tick(8);
			cfg_read();
			check(rd & (32'h1 << i), 32'h1 << i);
		end
		hw_vol = 1'b0;
		cfg_write_open = 1'b0;
		cfg_write(4'hF, 32'hFFFF_FFFF);
		cfg_write_open = 1'b1;
		cfg_read();
		check(rd & 32'hFFFF_0C00, 32'h0070_0000);
		// Reset in mid-run drops both drivers and every control bit
		cfg_write(4'hF, 32'h1100_0C00);
		rst_b = 1'b0;
		tick(2);
		rst_b = 1'b1;
		tick(1);
		check({30'h0, sh_oe, sc_oe}, 32'h0);
		cfg_read();
		check(rd & 32'hFFFF_FFF0, PIN_PORT_RESET);
		cfg_addr = 8'hEC;
		cfg_read();
		cfg_addr = PIN_PORT_OFFSET;
		check(rd, 32'h0000_0000);
		$display("misc done");
		complete_run();
	end
endmodule
`default_nettype wire
